// [dv/bsvl_stage_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// power stage and processor select lines
// ------------------------------------------------------------
module bsvl_stage_model (
	input wire logic core_clk,
	input wire logic [4:0] vid_req,
	input wire logic vid_float,
	input wire logic overload,
	input wire logic [3:0] duty,
	input wire logic upper_gate_drive,
	output logic [4:0] vid_pins,
	output logic switch_node_current_sense,
	output logic pwm_demand_cmp
);
	logic [3:0] ramp_q = 4'h0;

	// floating select lines read high through the pull-ups
	assign vid_pins = vid_float ? 5'h1f : vid_req;
	// with the upper switch off the node sits near ground, so the
	// comparator reads overcurrent; only the on-time sample is valid
	assign switch_node_current_sense = upper_gate_drive ? overload : 1'b1;
	always_ff @(posedge core_clk) begin
		ramp_q <= ramp_q + 4'h1;
		pwm_demand_cmp <= (ramp_q < duty);
	end
endmodule : bsvl_stage_model

// [dv/testbench.sv]
`timescale 1ns/1ps

module testbench;
	import bsvl_pkg::*;
	localparam int PGG = 40;
	localparam int PGB = 20;
	localparam int HH = 16;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] vid_req = 5'h00;
	logic [4:0] vid_pins;
	logic vid_float = 1'b0;
	logic overload = 1'b0;
	logic [3:0] duty = 4'h6;
	logic oe_in = 1'b1;
	logic en_above_off = 1'b1;
	logic lo97 = 1'b1;
	logic hi103 = 1'b0;
	logic hi113 = 1'b0;
	logic hard = 1'b0;
	logic ss_done = 1'b0;
	logic pwm, isense, ug, lg, f_out, f_oe_n, pg_out, pg_oe_n;
	logic ss_slow, ss_low, min_en, halt, seen_up;
	logic [8:0] sp;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] lfsr = 32'h6112;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int ups = 0;
	wire fault_pin = f_oe_n ? 1'b1 : f_out;
	wire pg_pin = pg_oe_n ? 1'b1 : pg_out;

	initial forever #25 core_clk = ~core_clk;

	bsvl_stage_model stage_u (.core_clk(core_clk), .vid_req(vid_req),
		.vid_float(vid_float), .overload(overload), .duty(duty),
		.upper_gate_drive(ug), .vid_pins(vid_pins),
		.switch_node_current_sense(isense), .pwm_demand_cmp(pwm));

	bsvl_top #(.PG_GOOD_CYCLES(PGG), .PG_BAD_CYCLES(PGB),
		.HARD_HOLD_CYCLES(HH)) dut_u (.core_clk(core_clk), .rst(rst),
		.volt_select_bit0(vid_pins[0]), .volt_select_bit1(vid_pins[1]),
		.volt_select_bit2(vid_pins[2]), .volt_select_bit3(vid_pins[3]),
		.volt_select_bit4(vid_pins[4]), .output_enable_in(oe_in),
		.enable_above_off_cmp(en_above_off), .below_97_cmp(lo97),
		.above_103_cmp(hi103), .above_113_cmp(hi113),
		.switch_node_current_sense(isense), .hard_limit_cmp(hard),
		.soft_start_done_cmp(ss_done), .pwm_demand_cmp(pwm),
		.upper_gate_drive(ug), .lower_gate_drive(lg), .fault_out(f_out),
		.fault_oe_n(f_oe_n), .power_good_out(pg_out),
		.power_good_oe_n(pg_oe_n), .ss_discharge_slow(ss_slow),
		.ss_force_low(ss_low), .min_override_en(min_en),
		.shutdown_out(halt), .setpoint_code(sp), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	function automatic logic [8:0] sp_exp(input logic [4:0] v);
		if (v == 5'h1f)
			return 9'h000;
		if (!v[4])
			return 9'h082 + 9'h005 * (9'h00f - {5'h00, v[3:0]});
		return 9'h0d2 + 9'h00a * (9'h00e - {5'h00, v[3:0]});
	endfunction : sp_exp

	task automatic chk_word(input logic [33:0] g, input logic [33:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_word

	task automatic chk_bit(input logic g, input logic e);
		chk_word({33'h0, g}, {33'h0, e});
	endtask : chk_bit

	task automatic clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask : clk

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// write address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back(r);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : axi_rd

	// ------------------------------------------------------------
	// output watcher and hang limit
	// ------------------------------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			results();
		end
		if (ss_low)
			seen_up = 1'b0;
		else if (ug)
			seen_up = 1'b1;
		if (lg === 1'b1)
			chk_bit(seen_up, 1'b1);
		// outputs are unknown until the first reset edge
		if (!rst)
			chk_bit(ug & lg, 1'b0);
		if (ug === 1'b1)
			ups++;
		if (bvalid && bready)
			chk_word({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (rvalid && rready)
			chk_word({rresp, rdata}, rq.pop_front());
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk(5);
		chk_bit(ug | lg, 1'b0);
		chk_bit(halt, 1'b1);
		chk_word(34'(sp), 34'h0);
		clk(1);
		rst <= 1'b0;
		axi_rd(4'h0, 34'h1);
		for (int i = 0; i < 32; i++) begin
			vid_req <= 5'(i);
			clk(5);
			chk_word(34'(sp), 34'(sp_exp(5'(i))));
			chk_bit(halt, i == 31);
			axi_rd(4'h8, 34'(sp_exp(5'(i))));
		end
		vid_float <= 1'b1;
		vid_req <= 5'h00;
		clk(5);
		chk_bit(halt, 1'b1);
		vid_float <= 1'b0;
		vid_req <= 5'h0a;
		tdone("select");
		lo97 <= 1'b0;
		clk(PGG / 2);
		chk_bit(pg_pin, 1'b0);
		chk_bit(min_en, 1'b0);
		clk(PGG / 2 + 8);
		chk_bit(pg_pin, 1'b1);
		ss_done <= 1'b1;
		hi103 <= 1'b1;
		clk(PGB / 2);
		hi103 <= 1'b0;
		clk(4);
		chk_bit(pg_pin, 1'b1);
		hi103 <= 1'b1;
		clk(PGB + 6);
		chk_bit(pg_pin, 1'b0);
		hi103 <= 1'b0;
		clk(PGG + 8);
		chk_bit(pg_pin, 1'b1);
		chk_bit(min_en, 1'b1);
		tdone("power good");
		lfsr = next_rand(lfsr);
		duty <= 4'h5 + {2'h0, lfsr[1:0]};
		overload <= 1'b1;
		clk(64);
		chk_bit(ss_slow, 1'b1);
		chk_bit(ss_low, 1'b0);
		overload <= 1'b0;
		clk(64);
		chk_bit(ss_slow, 1'b0);
		// a hard limit is a large overcurrent, so both comparators trip
		hard <= 1'b1;
		overload <= 1'b1;
		ss_done <= 1'b0;
		for (int k = 0; k < 40 && ss_low !== 1'b1; k++)
			clk(1);
		chk_bit(ss_low, 1'b1);
		hard <= 1'b0;
		overload <= 1'b0;
		clk(HH - 8);
		chk_bit(ss_low | ug, 1'b1);
		chk_bit(ug, 1'b0);
		clk(HH + 8);
		chk_bit(ss_low, 1'b0);
		chk_bit(min_en, 1'b0);
		ss_done <= 1'b1;
		clk(20);
		tdone("current limit");
		hi113 <= 1'b1;
		hi103 <= 1'b1;
		for (int k = 0; k < 12 && fault_pin !== 1'b0; k++)
			clk(1);
		chk_bit(fault_pin, 1'b0);
		clk(2);
		chk_bit(ug | lg, 1'b0);
		hi113 <= 1'b0;
		hi103 <= 1'b0;
		clk(30);
		chk_bit(fault_pin, 1'b0);
		oe_in <= 1'b0;
		clk(6);
		chk_bit(fault_pin, 1'b1);
		chk_bit(pg_pin, 1'b0);
		clk(80);
		chk_bit(ug | lg, 1'b0);
		oe_in <= 1'b1;
		clk(10);
		chk_bit(fault_pin, 1'b1);
		tdone("fault");
		clk(40);
		ups = 0;
		// a sync clock of 40 cycles, faster than the free-running period
		for (int k = 0; k < 12; k++) begin
			oe_in <= ~oe_in;
			clk(20);
		end
		chk_bit(ups > 20, 1'b1);
		tdone("sync");
		oe_in <= 1'b0;
		en_above_off <= 1'b0;
		clk(300);
		chk_bit(halt, 1'b0);
		oe_in <= 1'b1;
		en_above_off <= 1'b1;
		clk(20);
		oe_in <= 1'b0;
		en_above_off <= 1'b0;
		clk(620);
		chk_bit(halt, 1'b1);
		oe_in <= 1'b1;
		en_above_off <= 1'b1;
		clk(20);
		tdone("shutdown");
		axi_wr(4'h0, 32'h0, RESP_OKAY);
		clk(40);
		chk_bit(ug | lg, 1'b0);
		axi_rd(4'h0, 34'h0);
		axi_wr(4'h0, 32'h1, RESP_OKAY);
		axi_rd(4'h0, 34'h1);
		lfsr = next_rand(lfsr);
		axi_wr(4'hc, lfsr, RESP_DECERR);
		axi_rd(4'hc, {RESP_DECERR, 32'h0});
		axi_wr(4'h8, lfsr, RESP_OKAY);
		axi_rd(4'h8, 34'(sp_exp(5'h0a)));
		tdone("register bus");
		results();
	end
endmodule : testbench

// [hdl/bsvl_pkg.sv]
package bsvl_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int OSC_FREE_HZ = 300000;
	localparam int PG_GOOD_US = 1000;
	localparam int PG_BAD_US = 500;
	localparam int OFF_DLY_US = 30;
	localparam int HARD_HOLD_US = 500;
	localparam int CYC_PER_US = CLK_HZ / 1000000;
	// longest-time figures round down; least-time figures round up
	localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_FREE_HZ;
	localparam int PG_GOOD_CYC = PG_GOOD_US * CYC_PER_US;
	localparam int PG_BAD_CYC = PG_BAD_US * CYC_PER_US;
	localparam int OFF_DLY_CYC = OFF_DLY_US * CYC_PER_US;
	localparam int HARD_HOLD_CYC = HARD_HOLD_US * CYC_PER_US;
	localparam int CNT_W = 16;
	// synchroniser reset: select lines and both enable levels idle high,
	// so no false enable edge and no decoded setpoint follow reset
	localparam logic [13:0] SYNC_IDLE = 14'h007f;

	// ------------------------------------------------------------
	// select code decoding, setpoint in 10 mV units
	// ------------------------------------------------------------
	localparam logic [4:0] SHUTDOWN_CODE = 5'h1f;
	localparam logic [8:0] SP_LO_BASE = 9'h082;
	localparam logic [8:0] SP_LO_STEP = 9'h005;
	localparam logic [8:0] SP_HI_BASE = 9'h0d2;
	localparam logic [8:0] SP_HI_STEP = 9'h00a;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_SETPOINT = 4'h8;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int ST_PG = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_OFF = 2;
	localparam int ST_OTEMP = 3;
	localparam int ST_ILIM = 4;
	localparam int ST_SOFT = 5;
	localparam int ST_HARD = 6;
	localparam int ST_VID = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [4:0] {
		BSVL_OFF = 5'h01,
		BSVL_SOFT = 5'h02,
		BSVL_RUN = 5'h04,
		BSVL_HARD = 5'h08,
		BSVL_FAULT = 5'h10
	} bsvl_state_t;

endpackage : bsvl_pkg

// [hdl/bsvl_top.sv]
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - lower gate low while upper high or disabled
// - soft-start: lower held until first upper pulse
// - upper gate low while lower high or disabled
// - overcurrent during upper on enters current limit
// - moderate overload slowly discharges soft-start ramp
// - hard limit forces ramp low, then restarts
// - over 113 percent: fault low, gates off
// - fault latched until power or enable toggle
// - enable low releases fault output
// - power-good rises after 1ms in window
// - power-good falls after 500us out of window
// - enable low holds power-good low
// - 97/103/113 percent window drives outputs
// - all select bits high means shutdown
// - top bit 0: 1.30 to 2.05 V
// - top bit 1: 2.1 to 3.5 V, 11111 off
// - enable below overtemp level disables gates
// - enable low over 30us enters shutdown
// - oscillator locks to faster clock on enable
// - free-running oscillator at 300kHz
// - undervoltage override off during soft-start
module bsvl_top import bsvl_pkg::*; #(
	parameter int PG_GOOD_CYCLES = PG_GOOD_CYC,
	parameter int PG_BAD_CYCLES = PG_BAD_CYC,
	parameter int HARD_HOLD_CYCLES = HARD_HOLD_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic volt_select_bit0,
	input wire logic volt_select_bit1,
	input wire logic volt_select_bit2,
	input wire logic volt_select_bit3,
	input wire logic volt_select_bit4,
	input wire logic output_enable_in,
	input wire logic enable_above_off_cmp,
	input wire logic below_97_cmp,
	input wire logic above_103_cmp,
	input wire logic above_113_cmp,
	input wire logic switch_node_current_sense,
	input wire logic hard_limit_cmp,
	input wire logic soft_start_done_cmp,
	input wire logic pwm_demand_cmp,
	output logic upper_gate_drive,
	output logic lower_gate_drive,
	output logic fault_out,
	output logic fault_oe_n,
	output logic power_good_out,
	output logic power_good_oe_n,
	output logic ss_discharge_slow,
	output logic ss_force_low,
	output logic min_override_en,
	output logic shutdown_out,
	output logic [8:0] setpoint_code,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [8:0] decode_setpoint(input logic [4:0] code);
		logic [8:0] steps;
		steps = {5'h00, ~code[3:0]};
		if (code == SHUTDOWN_CODE) begin
			decode_setpoint = 9'h000;
		end else if (!code[4]) begin
			decode_setpoint = SP_LO_BASE + 9'(steps * SP_LO_STEP);
		end else begin
			// upper range starts at 11110, one code below all ones
			decode_setpoint = SP_HI_BASE
				+ 9'((steps - 9'h001) * SP_HI_STEP);
		end
	endfunction : decode_setpoint

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 16'h0001;
	endfunction : sat_inc

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 14;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	assign raw_in = {pwm_demand_cmp, soft_start_done_cmp, hard_limit_cmp,
		switch_node_current_sense, above_113_cmp, above_103_cmp,
		below_97_cmp, enable_above_off_cmp, output_enable_in,
		volt_select_bit4, volt_select_bit3, volt_select_bit2,
		volt_select_bit1, volt_select_bit0};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	logic [4:0] vid_s;
	logic en_s, en_off_s, low_s, high_s, ovp_s, ilim_s, hard_s;
	logic ssdone_s, pwm_s;
	assign vid_s = sync2_q[4:0];
	assign en_s = sync2_q[5];
	assign en_off_s = sync2_q[6];
	assign low_s = sync2_q[7];
	assign high_s = sync2_q[8];
	assign ovp_s = sync2_q[9];
	assign ilim_s = sync2_q[10];
	assign hard_s = sync2_q[11];
	assign ssdone_s = sync2_q[12];
	assign pwm_s = sync2_q[13];

	// ------------------------------------------------------------
	// state and counter registers; run_en_q, setpoint_q and the status bits are seen by software
	// ------------------------------------------------------------
	logic run_en_q;
	logic [8:0] setpoint_q;
	logic en_prev_q;
	logic [CNT_W-1:0] phase_q;
	logic [CNT_W-1:0] en_low_q;
	logic [CNT_W-1:0] off_cnt_q;
	logic [CNT_W-1:0] good_cnt_q;
	logic [CNT_W-1:0] bad_cnt_q;
	logic [CNT_W-1:0] hold_cnt_q;
	logic fault_q, pg_q, off_q, otemp_q, first_hi_q, ilim_q;
	logic upper_q, lower_q, slow_q;
	logic [1:0] up_age_q;
	bsvl_state_t state_q;

	// ------------------------------------------------------------
	// oscillator, sync and enable monitoring
	// ------------------------------------------------------------
	logic en_rise, period_end;
	assign en_rise = en_s && !en_prev_q;
	assign period_end = (phase_q == 16'(OSC_PERIOD_CYC - 1));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_prev_q <= 1'b1;
			phase_q <= '0;
		end else begin
			en_prev_q <= en_s;
			if (en_rise || period_end) begin
				phase_q <= '0;
			end else begin
				phase_q <= phase_q + 16'h0001;
			end
		end
	end

	// a sync clock's low phase is shorter than one free period, so it
	// is not mistaken for an overtemperature drop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_low_q <= '0;
			otemp_q <= 1'b0;
		end else begin
			en_low_q <= en_s ? '0 : sat_inc(en_low_q);
			otemp_q <= !en_s && (en_low_q >= 16'(OSC_PERIOD_CYC - 1));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			off_cnt_q <= '0;
			off_q <= 1'b1;
		end else begin
			off_cnt_q <= en_off_s ? '0 : sat_inc(off_cnt_q);
			off_q <= (vid_s == SHUTDOWN_CODE)
				|| (off_cnt_q >= 16'(OFF_DLY_CYC));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			setpoint_q <= 9'h000;
		end else begin
			setpoint_q <= decode_setpoint(vid_s);
		end
	end

	// ------------------------------------------------------------
	// overvoltage fault and power-good
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fault_q <= 1'b0;
		end else if (en_s && ovp_s) begin
			fault_q <= 1'b1;
		end else if (!en_s) begin
			fault_q <= 1'b0;
		end
	end

	logic in_window;
	assign in_window = !low_s && !high_s && !ovp_s;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			good_cnt_q <= '0;
			bad_cnt_q <= '0;
			pg_q <= 1'b0;
		end else if (!en_s) begin
			good_cnt_q <= '0;
			bad_cnt_q <= '0;
			pg_q <= 1'b0;
		end else begin
			good_cnt_q <= in_window ? sat_inc(good_cnt_q) : '0;
			bad_cnt_q <= in_window ? '0 : sat_inc(bad_cnt_q);
			if (good_cnt_q >= 16'(PG_GOOD_CYCLES)) begin
				pg_q <= 1'b1;
			end else if (bad_cnt_q >= 16'(PG_BAD_CYCLES)) begin
				pg_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// soft-start and current limit sequencing
	// ------------------------------------------------------------
	logic disabled, upper_fall, sample_ok;
	assign disabled = off_q || fault_q || otemp_q || !run_en_q;
	// the current comparator is read just before each upper turn-off set by PWM demand or period end
	assign upper_fall = upper_q && (!pwm_s || period_end);
	// the comparator path lags the pin by two cycles; a shorter pulse
	// would report the off-time reading, so it leaves the latch alone
	assign sample_ok = upper_fall && (up_age_q >= 2'h2);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= BSVL_OFF;
			hold_cnt_q <= '0;
		end else begin
			case (state_q)
			BSVL_OFF: begin
				if (!disabled) begin
					state_q <= BSVL_SOFT;
				end
			end
			BSVL_SOFT, BSVL_RUN: begin
				if (fault_q) begin
					state_q <= BSVL_FAULT;
				end else if (disabled) begin
					state_q <= BSVL_OFF;
				end else if (sample_ok && ilim_s && hard_s) begin
					state_q <= BSVL_HARD;
					hold_cnt_q <= '0;
				end else if (state_q == BSVL_SOFT && ssdone_s) begin
					state_q <= BSVL_RUN;
				end
			end
			BSVL_HARD: begin
				hold_cnt_q <= sat_inc(hold_cnt_q);
				if (fault_q) begin
					state_q <= BSVL_FAULT;
				end else if (hold_cnt_q >= 16'(HARD_HOLD_CYCLES - 1)) begin
					state_q <= BSVL_OFF;
				end
			end
			BSVL_FAULT: begin
				if (!fault_q) begin
					state_q <= BSVL_OFF;
				end
			end
			default: begin
				state_q <= BSVL_OFF;
			end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ilim_q <= 1'b0;
			slow_q <= 1'b0;
		end else if (sample_ok) begin
			ilim_q <= ilim_s;
			slow_q <= ilim_s && !hard_s;
		end else if (state_q == BSVL_OFF) begin
			ilim_q <= 1'b0;
			slow_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// gate drives
	// ------------------------------------------------------------
	logic active, want_up;
	assign active = (state_q == BSVL_SOFT || state_q == BSVL_RUN) && !disabled;
	// a forced turn-off every period keeps the current sample alive
	assign want_up = active && pwm_s && !period_end;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			upper_q <= 1'b0;
			lower_q <= 1'b0;
			up_age_q <= 2'h0;
			first_hi_q <= 1'b0;
		end else begin
			if (!upper_q) begin
				up_age_q <= 2'h0;
			end else if (up_age_q != 2'h3) begin
				up_age_q <= up_age_q + 2'h1;
			end
			upper_q <= want_up && !lower_q;
			lower_q <= active && !want_up && !upper_q
				&& first_hi_q;
			if (state_q != BSVL_SOFT && state_q != BSVL_RUN) begin
				first_hi_q <= 1'b0;
			end else if (upper_q) begin
				first_hi_q <= 1'b1;
			end
		end
	end

	assign upper_gate_drive = upper_q;
	assign lower_gate_drive = lower_q;
	assign fault_out = 1'b0;
	assign fault_oe_n = !(fault_q && en_s);
	assign power_good_out = 1'b0;
	assign power_good_oe_n = pg_q;
	assign ss_discharge_slow = slow_q;
	assign ss_force_low = (state_q == BSVL_HARD) || (state_q == BSVL_OFF);
	assign min_override_en = (state_q == BSVL_RUN);
	assign shutdown_out = off_q;
	assign setpoint_code = setpoint_q;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic aw_have_q, w_have_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_strb0_q;
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0000_0000;
			w_strb0_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			run_en_q <= CTRL_RUN_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (aw_have_q && w_have_q) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_q == REG_CTRL) begin
					s_axi_bresp <= RESP_OKAY;
					if (w_strb0_q) begin
						run_en_q <= w_data_q[0];
					end
				end else if (aw_addr_q == REG_STATUS || aw_addr_q == REG_SETPOINT) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic [31:0] status_word;
	assign status_word = {19'h00000, vid_s, 1'b0, state_q == BSVL_HARD,
		state_q == BSVL_SOFT, ilim_q, otemp_q, off_q, fault_q, pg_q};
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
			REG_CTRL: s_axi_rdata <= {31'h0000_0000, run_en_q};
			REG_STATUS: s_axi_rdata <= status_word;
			REG_SETPOINT: s_axi_rdata <= {23'h000000, setpoint_q};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_DECERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence hard_trip_s;
		active && sample_ok && ilim_s && hard_s && !fault_q;
	endsequence
	sequence hold_low_s;
		ss_force_low [*8];
	endsequence

	chk_gates_exclusive: assert property (
		!(upper_gate_drive && lower_gate_drive))
		else $error("both gate drives high");
	chk_gates_off_disabled: assert property (
		disabled |=> !upper_gate_drive && !lower_gate_drive)
		else $error("gate drive while disabled");
	chk_soft_lower_hold: assert property (
		(state_q == BSVL_SOFT) && !first_hi_q |-> !lower_gate_drive)
		else $error("lower gate before first upper pulse");
	chk_hard_limit_hold: assert property (
		hard_trip_s |=> hold_low_s)
		else $error("hard limit did not hold ramp low");
	chk_ovp_fault_set: assert property (
		en_s && ovp_s |=> fault_q ##1 !fault_oe_n || !en_s)
		else $error("overvoltage did not raise fault");
	chk_fault_latch_hold: assert property (
		fault_q && en_s |=> fault_q)
		else $error("fault dropped while enabled");
	chk_fault_released: assert property (
		!en_s |-> fault_oe_n)
		else $error("fault driven while enable low");
	chk_pg_rise_time: assert property (
		$rose(pg_q) |-> $past(good_cnt_q) >= 16'(PG_GOOD_CYCLES))
		else $error("power-good rose early");
	chk_pg_low_disabled: assert property (
		!en_s |=> !pg_q)
		else $error("power-good high with enable low");
	chk_vid_shutdown: assert property (
		vid_s == SHUTDOWN_CODE |=> off_q && setpoint_q == 9'h000)
		else $error("shutdown code not honoured");
	chk_min_soft_off: assert property (
		state_q == BSVL_SOFT |-> !min_override_en)
		else $error("override enabled during soft-start");

endmodule : bsvl_top
